/* File: rtl/gs_selector.sv */
// Setting group selector with force, remote change and priority requests
// Assumes requests synchronous to ref_clk; register port never stalls
`timescale 1ns/1ps
`default_nettype none
module gs_selector (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [gs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [gs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [gs_pkg::NUM_GROUPS-1:0] group_request,
  output logic [gs_pkg::GRP_W-1:0] active_group_out,
  output logic [gs_pkg::NUM_GROUPS-1:0] active_group_onehot,
  output logic force_active,
  output logic fail_not_configured,
  output logic fail_lower_priority,
  output logic fail_force,
  output logic [gs_pkg::NUM_GROUPS-1:0] group_defaults_load
);
  typedef struct packed {
    logic [gs_pkg::GRP_W-1:0] active;
    logic [gs_pkg::NUM_GROUPS-1:0] onehot;
    logic [gs_pkg::GRP_W-1:0] used;
    logic force_en;
    logic force_prev;
    logic [gs_pkg::SEL_W-1:0] forced;
    logic [gs_pkg::SEL_W-1:0] remote;
    logic [gs_pkg::NUM_GROUPS-1:0] req_prev;
    logic [gs_pkg::FAIL_W-1:0] sticky;
    logic [gs_pkg::FAIL_W-1:0] fail;
    logic [gs_pkg::NUM_GROUPS-1:0] defaults;
    logic [gs_pkg::DATA_W-1:0] rdata;
  } gs_state_s;

  gs_state_s q;
  gs_state_s d;

  logic [gs_pkg::NUM_GROUPS-1:0] en_mask;
  logic [gs_pkg::NUM_GROUPS-1:0] held;
  logic [gs_pkg::NUM_GROUPS-1:0] rise;
  logic [gs_pkg::NUM_GROUPS-1:0] first_held;
  logic hfound;
  logic [gs_pkg::GRP_W-1:0] hidx;
  logic wr_ctrl;
  logic wr_remote;
  logic [gs_pkg::SEL_W-1:0] wr_forced;
  logic [gs_pkg::SEL_W-1:0] wr_target;
  logic [gs_pkg::GRP_W-1:0] wr_used;

  // Enabled groups count up from group one
  genvar g;
  generate
    for (g = 0; g < gs_pkg::NUM_GROUPS; g++) begin : g_en
      assign en_mask[g] = (g <= int'(q.used));
    end
  endgenerate

  assign held = group_request & en_mask;
  assign rise = held & ~q.req_prev;
  assign wr_ctrl = reg_wr && (reg_addr == gs_pkg::OFS_CTRL);
  assign wr_remote = reg_wr && (reg_addr == gs_pkg::OFS_REMOTE);
  assign wr_forced = reg_wdata[gs_pkg::CTRL_FORCED_LSB +: gs_pkg::SEL_W];
  assign wr_target = reg_wdata[gs_pkg::REMOTE_SEL_LSB +: gs_pkg::SEL_W];
  assign wr_used = reg_wdata[gs_pkg::CTRL_USED_LSB +: gs_pkg::GRP_W];

  // Highest held request; held higher group blocks all below it
  gs_prio u_prio (
    .vec(held),
    .found(hfound),
    .idx(hidx),
    .first(first_held)
  );

  function automatic logic fits(input logic [gs_pkg::SEL_W-1:0] sel,
                                input logic [gs_pkg::GRP_W-1:0] used);
    fits = (sel != gs_pkg::SEL_NONE) && ((sel - 4'h1) <= {1'b0, used});
  endfunction : fits

  function automatic logic [gs_pkg::NUM_GROUPS-1:0] mask_of(
      input logic [gs_pkg::GRP_W-1:0] used);
    mask_of = '0;
    for (int i = 0; i < gs_pkg::NUM_GROUPS; i++) begin
      mask_of[i] = (i[gs_pkg::GRP_W-1:0] <= used);
    end
  endfunction : mask_of

  always_comb begin
    d = q;
    d.fail = '0;
    d.rdata = '0;
    d.req_prev = group_request;
    d.force_prev = q.force_en;
    // Register writes
    if (wr_ctrl) begin
      d.force_en = reg_wdata[gs_pkg::CTRL_FORCE_BIT];
      d.used = wr_used;
      d.forced = wr_forced;
      if (wr_forced != gs_pkg::SEL_NONE &&
          (!reg_wdata[gs_pkg::CTRL_FORCE_BIT] || !fits(wr_forced, wr_used))) begin
        d.fail[gs_pkg::FAIL_FORCE] = 1'b1;
      end
    end
    if (wr_remote) begin
      d.remote = wr_target;
    end
    if (|(group_request & ~q.req_prev & ~en_mask)) begin
      d.fail[gs_pkg::FAIL_NOT_CFG] = 1'b1;
    end
    // Selection
    if (q.used == gs_pkg::RST_USED) begin
      d.active = gs_pkg::RST_ACTIVE;
    end else if (q.force_en) begin
      if (fits(q.forced, q.used)) begin
        d.active = q.forced[gs_pkg::GRP_W-1:0] - 3'h1;
      end
    end else begin
      if (hfound && (rise != '0 || q.force_prev)) begin
        d.active = hidx;
        if (|(rise & ~first_held)) begin
          d.fail[gs_pkg::FAIL_LOWER] = 1'b1;
        end
      end else if (wr_remote && wr_target != gs_pkg::SEL_NONE) begin
        if (!fits(wr_target, q.used)) begin
          d.fail[gs_pkg::FAIL_NOT_CFG] = 1'b1;
        end else if (hfound && ({1'b0, hidx} < wr_target - 4'h1)) begin
          d.fail[gs_pkg::FAIL_LOWER] = 1'b1;
        end else begin
          d.active = wr_target[gs_pkg::GRP_W-1:0] - 3'h1;
        end
      end
    end
    // Never leave an unused group active
    if (d.active > d.used) begin
      d.active = gs_pkg::RST_ACTIVE;
    end
    for (int i = 0; i < gs_pkg::NUM_GROUPS; i++) begin
      d.onehot[i] = (d.active == i[gs_pkg::GRP_W-1:0]);
    end
    d.defaults = mask_of(d.used) & ~mask_of(q.used);
    // Sticky fails: set wins over write-one clear
    d.sticky = q.sticky;
    if (reg_wr && reg_addr == gs_pkg::OFS_STATUS) begin
      d.sticky = q.sticky & ~reg_wdata[gs_pkg::STAT_FAIL_LSB +: gs_pkg::FAIL_W];
    end
    d.sticky = d.sticky | d.fail;
    // Read data one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        gs_pkg::OFS_CTRL: begin
          d.rdata[gs_pkg::CTRL_FORCE_BIT] = q.force_en;
          d.rdata[gs_pkg::CTRL_USED_LSB +: gs_pkg::GRP_W] = q.used;
          d.rdata[gs_pkg::CTRL_FORCED_LSB +: gs_pkg::SEL_W] = q.forced;
        end
        gs_pkg::OFS_REMOTE: begin
          d.rdata[gs_pkg::REMOTE_SEL_LSB +: gs_pkg::SEL_W] = q.remote;
        end
        gs_pkg::OFS_STATUS: begin
          d.rdata[gs_pkg::STAT_ACTIVE_LSB +: gs_pkg::GRP_W] = q.active;
          d.rdata[gs_pkg::STAT_ONEHOT_LSB +: gs_pkg::NUM_GROUPS] = q.onehot;
          d.rdata[gs_pkg::STAT_FORCE_BIT] = q.force_en;
          d.rdata[gs_pkg::STAT_FAIL_LSB +: gs_pkg::FAIL_W] = q.sticky;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.active <= gs_pkg::RST_ACTIVE;
      q.onehot <= 8'h01;
      q.used <= gs_pkg::RST_USED;
      q.force_en <= gs_pkg::RST_FORCE;
      q.forced <= gs_pkg::SEL_NONE;
      q.remote <= gs_pkg::SEL_NONE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign active_group_out = q.active;
  assign active_group_onehot = q.onehot;
  assign force_active = q.force_en;
  assign fail_not_configured = q.fail[gs_pkg::FAIL_NOT_CFG];
  assign fail_lower_priority = q.fail[gs_pkg::FAIL_LOWER];
  assign fail_force = q.fail[gs_pkg::FAIL_FORCE];
  assign group_defaults_load = q.defaults;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_onehot_tracks: assert property (
    $onehot(active_group_onehot) && active_group_onehot[active_group_out])
    else $error("one-hot flags disagree with active group");

  a_active_enabled: assert property (active_group_out <= q.used)
    else $error("active group is not enabled");

  a_single_idle: assert property (
    (q.used == gs_pkg::RST_USED) |=> active_group_out == gs_pkg::RST_ACTIVE)
    else $error("single used group is not group one");

  a_force_applies: assert property (
    (q.force_en && fits(q.forced, q.used) && q.used != gs_pkg::RST_USED && !reg_wr)
    |=> {1'b0, active_group_out} == $past(q.forced) - 4'h1)
    else $error("forced group not applied");

  a_force_ignores: assert property (
    (q.force_en && !fits(q.forced, q.used) && !reg_wr) |=> $stable(active_group_out))
    else $error("requests acted on during force");

  a_group_one_wins: assert property (
    (rise[0] && !q.force_en && q.used != gs_pkg::RST_USED && !reg_wr)
    |=> active_group_out == 3'h0)
    else $error("group one request did not win");

  a_held_one_blocks: assert property (
    (group_request[0] && !q.force_en && active_group_out == 3'h0 && !reg_wr)
    [*2] |=> active_group_out == 3'h0)
    else $error("held group one was overridden");

  a_pulse_latches: assert property (
    (!q.force_en && !q.force_prev && group_request == '0 && !reg_wr)
    |=> $stable(active_group_out))
    else $error("pulse selected group did not hold");

  a_force_release: assert property (
    (q.force_prev && !q.force_en && hfound && q.used != gs_pkg::RST_USED && !reg_wr)
    |=> active_group_out == $past(hidx))
    else $error("levels did not regain control after force");

  a_remote_blocked: assert property (
    (wr_remote && !q.force_en && !q.force_prev && rise == '0 && hfound
     && fits(wr_target, q.used)
     && {1'b0, hidx} < wr_target - 4'h1)
    |=> $stable(active_group_out) && fail_lower_priority)
    else $error("remote change beat a held higher request");

  a_not_cfg_flag: assert property (
    |(group_request & ~q.req_prev & ~en_mask) |=> fail_not_configured)
    else $error("unconfigured request not flagged");

  a_status_read: assert property (
    (reg_rd && reg_addr == gs_pkg::OFS_STATUS)
    |=> reg_rdata[gs_pkg::GRP_W-1:0] == $past(active_group_out))
    else $error("status read shows wrong active group");
endmodule : gs_selector
`default_nettype wire

/* File: inc/gs_pkg.sv */
// Constants for the setting group selector
// Assumes a 32-bit register port with 4-bit byte addresses
package gs_pkg;
  localparam int unsigned NUM_GROUPS = 8;
  localparam int unsigned GRP_W = 3;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REMOTE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_FORCE_BIT = 0;
  localparam int unsigned CTRL_USED_LSB = 4;
  localparam int unsigned CTRL_FORCED_LSB = 8;
  // Remote change register field
  localparam int unsigned REMOTE_SEL_LSB = 0;
  // Status register fields
  localparam int unsigned STAT_ACTIVE_LSB = 0;
  localparam int unsigned STAT_ONEHOT_LSB = 8;
  localparam int unsigned STAT_FORCE_BIT = 16;
  localparam int unsigned STAT_FAIL_LSB = 24;

  // Fail flag positions
  localparam int unsigned FAIL_NOT_CFG = 0;
  localparam int unsigned FAIL_LOWER = 1;
  localparam int unsigned FAIL_FORCE = 2;
  localparam int unsigned FAIL_W = 3;

  // Reset values
  localparam logic [GRP_W-1:0] RST_ACTIVE = 3'h0;
  localparam logic [GRP_W-1:0] RST_USED = 3'h0;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
  localparam logic RST_FORCE = 1'b0;
endpackage : gs_pkg

/* File: rtl/gs_prio.sv */
// Fixed-priority finder: lowest index of a set bit wins
// Purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module gs_prio (
  input wire logic [gs_pkg::NUM_GROUPS-1:0] vec,
  output logic found,
  output logic [gs_pkg::GRP_W-1:0] idx,
  output logic [gs_pkg::NUM_GROUPS-1:0] first
);
  logic [gs_pkg::NUM_GROUPS:0] seen;

  assign seen[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < gs_pkg::NUM_GROUPS; g++) begin : g_chain
      assign seen[g+1] = seen[g] | vec[g];
      assign first[g] = vec[g] & ~seen[g];
    end
  endgenerate

  assign found = seen[gs_pkg::NUM_GROUPS];

  always_comb begin
    idx = '0;
    for (int i = 0; i < gs_pkg::NUM_GROUPS; i++) begin
      if (first[i]) begin
        idx = idx | i[gs_pkg::GRP_W-1:0];
      end
    end
  end
endmodule : gs_prio
`default_nettype wire

/* File: bench/gs_req_src.sv */
// Request source standing in for protection logic and digital inputs
// Assumes the bench gives hold and pulse commands on ref_clk edges
`timescale 1ns/1ps
`default_nettype none
module gs_req_src (
  input wire logic ref_clk,
  input wire logic [7:0] hold_lvl,
  input wire logic [7:0] fire_pls,
  output logic [7:0] group_request
);
  logic [7:0] req_q = 8'h00;
  // Levels stay up, pulses last one cycle
  always @(posedge ref_clk) begin
    req_q <= hold_lvl | fire_pls;
  end
  assign group_request = req_q;
endmodule : gs_req_src
`default_nettype wire

/* File: bench/test_gs_selector.sv */
// Self-checking bench for the setting group selector
// Assumes gs_pkg, gs_selector and gs_req_src are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_gs_selector;
  localparam logic [3:0] CT = gs_pkg::OFS_CTRL;
  localparam logic [3:0] RM = gs_pkg::OFS_REMOTE;
  localparam logic [3:0] ST = gs_pkg::OFS_STATUS;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] hold_lvl = 8'h00, fire_pls = 8'h00, group_request, onehot, dl_load;
  logic [7:0] dl_seen = 8'h00;
  logic [2:0] active;
  logic force_on, fl_cfg, fl_low, fl_frc;
  logic [2:0] fail_seen = 3'h0;
  int miscompares = 0, tests_run = 0;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) dl_seen <= rst_n ? (dl_seen | dl_load) : 8'h00;
  // Fail pulses gathered until the bench clears the sticky flags
  always @(posedge ref_clk) begin
    if (!rst_n || (reg_wr && reg_addr == ST)) begin
      fail_seen <= 3'h0;
    end else begin
      fail_seen <= fail_seen | {fl_frc, fl_low, fl_cfg};
    end
  end

  gs_req_src u_src (.ref_clk(ref_clk), .hold_lvl(hold_lvl), .fire_pls(fire_pls),
    .group_request(group_request));
  gs_selector u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .group_request(group_request), .active_group_out(active),
    .active_group_onehot(onehot), .force_active(force_on), .fail_not_configured(fl_cfg),
    .fail_lower_priority(fl_low), .fail_force(fl_frc), .group_defaults_load(dl_load));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, 32'h0);
  endtask : rd

  task automatic stat(input logic [2:0] g, input logic fo, input logic [2:0] f);
    rd(ST, {5'h0, f, 7'h0, fo, 8'h01 << g, 5'h0, g});
    chk(32'(fail_seen), 32'(f));
    chk(32'(force_on), 32'(fo));
  endtask : stat

  task automatic clr();
    wr(ST, 32'h0700_0000);
  endtask : clr

  task automatic pls(input logic [7:0] p);
    @(posedge ref_clk);
    fire_pls <= p;
    @(posedge ref_clk);
    fire_pls <= 8'h00;
  endtask : pls

  task automatic lvl(input logic [7:0] v);
    @(posedge ref_clk);
    hold_lvl <= v;
  endtask : lvl

  task automatic act(input logic [2:0] g);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(32'(active), 32'(g));
    chk(32'(onehot), 32'(8'h01 << g));
  endtask : act

  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    stat(3'd0, 1'b0, 3'd0);
    rd(CT, 32'h0);
    rd(4'hc, 32'h0);
    pls(8'h02);
    act(3'd0);
    clr();
    wr(CT, 32'h70);
    pls(8'h02);
    act(3'd1);
    chk(32'(dl_seen), 32'hfe);
    for (int i = 7; i >= 0; i--) begin
      pls(8'h01 << i);
      act(3'(i));
    end
    pls(8'ha4);
    act(3'd2);
    lvl(8'h18);
    act(3'd3);
    pls(8'h40);
    act(3'd3);
    stat(3'd3, 1'b0, 3'b010);
    clr();
    pls(8'h02);
    act(3'd1);
    lvl(8'h80);
    act(3'd7);
    pls(8'h20);
    act(3'd5);
    lvl(8'h01);
    act(3'd0);
    pls(8'h02);
    act(3'd0);
    lvl(8'h02);
    act(3'd1);
    wr(RM, 32'h5);
    act(3'd1);
    wr(RM, 32'h1);
    act(3'd0);
    stat(3'd0, 1'b0, 3'b010);
    clr();
    lvl(8'h00);
    wr(CT, 32'h20);
    pls(8'h20);
    wr(RM, 32'h6);
    act(3'd0);
    stat(3'd0, 1'b0, 3'b001);
    clr();
    pls(8'h04);
    act(3'd2);
    pls(8'h08);
    act(3'd2);
    wr(CT, 32'h71);
    wr(CT, 32'h471);
    act(3'd3);
    pls(8'h01);
    lvl(8'h20);
    act(3'd3);
    stat(3'd3, 1'b1, 3'b001);
    clr();
    wr(CT, 32'h70);
    act(3'd5);
    lvl(8'h00);
    wr(CT, 32'h271);
    wr(CT, 32'h70);
    act(3'd1);
    wr(CT, 32'h370);
    wr(CT, 32'h611);
    act(3'd1);
    stat(3'd1, 1'b1, 3'b100);
    give_verdict();
  end
endmodule : test_gs_selector
`default_nettype wire
